/* File: rtl/pfc_pkg.sv */
// pfc_pkg: register map, field layout and constants of the dual-slope pwm timer
// assumes a 32-bit avalon-mm slave with word addressing by byte offset
package pfc_pkg;
  localparam int unsigned AW = 6;
  localparam logic [5:0] OFF_CTRL   = 6'h00;
  localparam logic [5:0] OFF_CMPA   = 6'h04;
  localparam logic [5:0] OFF_CMPB   = 6'h08;
  localparam logic [5:0] OFF_CAPT   = 6'h0C;
  localparam logic [5:0] OFF_COUNT  = 6'h10;
  localparam logic [5:0] OFF_FLAGS  = 6'h14;
  localparam logic [5:0] OFF_IEN    = 6'h18;
  localparam logic [5:0] OFF_PIN    = 6'h1C;
  // ctrl fields
  localparam int unsigned CTRL_WGM_LSB  = 0;
  localparam int unsigned CTRL_COMA_LSB = 4;
  localparam int unsigned CTRL_COMB_LSB = 6;
  localparam int unsigned CTRL_CS_LSB   = 8;
  // flag bits
  localparam int unsigned FLG_OVF  = 0;
  localparam int unsigned FLG_CMPA = 1;
  localparam int unsigned FLG_CMPB = 2;
  localparam int unsigned FLG_CAPT = 3;
  // pin register fields: dir a, dir b, enable a, enable b
  localparam int unsigned PIN_DIRA = 0;
  localparam int unsigned PIN_DIRB = 1;
  localparam int unsigned PIN_ENA  = 2;
  localparam int unsigned PIN_ENB  = 3;
  localparam logic [3:0]  WGM_PFC_CAPT = 4'h8;
  localparam logic [3:0]  WGM_PFC_CMPA = 4'h9;
  localparam logic [1:0]  COM_OFF    = 2'h0;
  localparam logic [1:0]  COM_TOGGLE = 2'h1;
  localparam logic [1:0]  COM_NONINV = 2'h2;
  localparam logic [1:0]  COM_INV    = 2'h3;
  localparam logic [15:0] BOTTOM     = 16'h0000;
  localparam logic [15:0] ONE16      = 16'h0001;
  // prescaler select codes: 0 stopped, 1..5 = /1,/8,/64,/256,/1024
  localparam logic [2:0]  CS_STOP = 3'h0;
  localparam logic [2:0]  CS_1    = 3'h1;
  localparam logic [2:0]  CS_8    = 3'h2;
  localparam logic [2:0]  CS_64   = 3'h3;
  localparam logic [2:0]  CS_256  = 3'h4;
  localparam logic [2:0]  CS_1024 = 3'h5;
  localparam logic [9:0]  DIV_8    = 10'h007;
  localparam logic [9:0]  DIV_64   = 10'h03F;
  localparam logic [9:0]  DIV_256  = 10'h0FF;
  localparam logic [9:0]  DIV_1024 = 10'h3FF;
endpackage : pfc_pkg

/* File: rtl/pfc_prescaler.sv */
// pfc_prescaler: divides the i/o clock into a one-cycle timer tick enable
// assumes clock and rst_n of the timer core; select changes restart the divider
module pfc_prescaler (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [2:0] clk_sel,
  output logic            timer_tick
);
  logic [9:0] div_reg;
  logic [9:0] div_next;
  logic [9:0] limit;
  logic [2:0] sel_reg;

  always_comb begin
    unique case (clk_sel)
      pfc_pkg::CS_8:    limit = pfc_pkg::DIV_8;
      pfc_pkg::CS_64:   limit = pfc_pkg::DIV_64;
      pfc_pkg::CS_256:  limit = pfc_pkg::DIV_256;
      pfc_pkg::CS_1024: limit = pfc_pkg::DIV_1024;
      default:          limit = '0;
    endcase
    if (clk_sel != sel_reg || div_reg >= limit) begin
      div_next = '0;
    end else begin
      div_next = div_reg + 10'h001;
    end
  end

  // tick is a clock enable, never a second clock
  assign timer_tick = (clk_sel != pfc_pkg::CS_STOP) && (clk_sel <= pfc_pkg::CS_1024)
                      && (clk_sel == sel_reg) && (div_reg >= limit); // R15 R16

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_reg <= '0;
      sel_reg <= pfc_pkg::CS_STOP;
    end else begin
      div_reg <= div_next;
      sel_reg <= clk_sel;
    end
  end
endmodule : pfc_prescaler

/* File: rtl/pfc_timer.sv */
// pfc_timer: 16-bit dual-slope phase and frequency correct pwm timer
// assumes avalon-mm master on clock; output pins drive an external load
// Operation
// R01: modes 8 and 9 select dual-slope pwm
// R02: count bottom to top, then back down
// R03: top from capture_top (8) or compare_a (9)
// R04: count holds top for one tick
// R05: non-inverting: clear up-match, set down-match
// R06: mode two non-inverted, three inverted
// R07: compare buffers load only at bottom
// R08: overflow flag set at bottom reload
// R09: top source flag set at top
// R10: channel flag set on compare match
// R11: software keeps top at least 0x0003
// R12: software keeps top above compare values; the bench writes compare values up to and equal to top
// R13: pin driven only with direction and enable; the output enable follows the direction bit alone
// R14: bottom value gives low, top gives high
// R15: tick is clock divided by prescaler
// R16: fully synchronous, tick is clock enable
// R17: software picks top source by use
// R18: mode one with top mode bit toggles a
// R19: mode zero or disabled keeps port function
// R20: flags sticky until cleared, maskable interrupt
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
module pfc_timer (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        port_a_out,
  input  wire logic        port_b_out,
  output logic             pin_a_o,
  output logic             pin_a_oe,
  output logic             pin_b_o,
  output logic             pin_b_oe,
  output logic             irq
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        down_reg;
  logic        down_next;
  logic [15:0] cmpa_reg;    // active compare values
  logic [15:0] cmpa_next;
  logic [15:0] cmpb_reg;
  logic [15:0] cmpb_next;
  logic [15:0] bufa_reg;    // software-written buffers
  logic [15:0] bufa_next;
  logic [15:0] bufb_reg;
  logic [15:0] bufb_next;
  logic [15:0] capt_reg;
  logic [15:0] capt_next;
  logic [10:0] ctrl_reg;
  logic [10:0] ctrl_next;
  logic [3:0]  flag_reg;
  logic [3:0]  flag_next;
  logic [3:0]  ien_reg;
  logic [3:0]  ien_next;
  logic [3:0]  pin_reg;
  logic [3:0]  pin_next;
  logic        oca_reg;
  logic        oca_next;
  logic        ocb_reg;
  logic        ocb_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        ack_reg;
  logic        ack_next;

  logic        tick;
  logic [3:0]  wgm;
  logic [1:0]  coma;
  logic [1:0]  comb;
  logic        pfc_mode;
  logic [15:0] top;
  logic        at_top;
  logic        at_bottom;
  logic        reload;
  logic        slope_down;
  logic        match_a;
  logic        match_b;
  logic        req_new;
  logic        wr_cyc;
  logic        rd_cyc;
  logic [3:0]  flag_set;

  assign wgm  = ctrl_reg[pfc_pkg::CTRL_WGM_LSB +: 4];
  assign coma = ctrl_reg[pfc_pkg::CTRL_COMA_LSB +: 2];
  assign comb = ctrl_reg[pfc_pkg::CTRL_COMB_LSB +: 2];
  assign pfc_mode = (wgm == pfc_pkg::WGM_PFC_CAPT) || (wgm == pfc_pkg::WGM_PFC_CMPA); // R01
  assign top = (wgm == pfc_pkg::WGM_PFC_CMPA) ? cmpa_reg : capt_reg; // R03

  pfc_prescaler u_presc (
    .clock      (clock),
    .rst_n      (rst_n),
    .clk_sel    (ctrl_reg[pfc_pkg::CTRL_CS_LSB +: 3]),
    .timer_tick (tick)
  );

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // next waveform level for one channel on a tick
  function automatic logic wave_next(input logic cur, input logic [1:0] com,
                                     input logic match, input logic down,
                                     input logic tog_ok);
    logic lvl;
    lvl = cur;
    if (match) begin
      unique case (com)
        pfc_pkg::COM_NONINV: lvl = down;             // R05 R06
        pfc_pkg::COM_INV:    lvl = !down;            // R06
        pfc_pkg::COM_TOGGLE: lvl = tog_ok ? !cur : cur; // R18
        default:             lvl = cur;
      endcase
    end
    wave_next = lvl;
  endfunction : wave_next

  // slope a compare match acts on: top counts as the falling slope and bottom as the
  // rising one, so compare values at either extreme give a steady level
  function automatic logic match_down(input logic [15:0] cnt, input logic [15:0] tp,
                                      input logic down);
    if (cnt == tp) begin
      match_down = 1'b1;
    end else if (cnt == pfc_pkg::BOTTOM) begin
      match_down = 1'b0;
    end else begin
      match_down = down;
    end
  endfunction : match_down

  // one wait state: read data is loaded on the first edge, a write lands on the
  // edge at which waitrequest is seen low
  assign req_new = (avs_read || avs_write) && !ack_reg;
  assign wr_cyc  = avs_write && ack_reg;
  assign rd_cyc  = avs_read && !ack_reg;
  assign avs_waitrequest = req_new;
  assign avs_readdata = rdata_reg;

  assign at_top     = (cnt_reg == top);
  assign at_bottom  = (cnt_reg == pfc_pkg::BOTTOM);
  assign reload     = tick && pfc_mode && at_bottom; // R07 R08
  assign slope_down = match_down(cnt_reg, top, down_reg); // R14
  assign match_a   = tick && pfc_mode && (cnt_reg == cmpa_reg); // R10
  assign match_b   = tick && pfc_mode && (cnt_reg == cmpb_reg); // R10

  // counter, direction, double buffer reload
  always_comb begin
    cnt_next  = cnt_reg;
    down_next = down_reg;
    cmpa_next = cmpa_reg;
    cmpb_next = cmpb_reg;
    if (reload) begin
      cmpa_next = bufa_reg; // R07
      cmpb_next = bufb_reg; // R07
    end
    if (tick && pfc_mode) begin // R16
      if (!down_reg) begin
        // a stale top of zero must not wrap the count below bottom
        if (cnt_reg >= top && !at_bottom) begin
          down_next = 1'b1; // R04
          cnt_next  = cnt_reg - pfc_pkg::ONE16; // R02
        end else begin
          cnt_next = cnt_reg + pfc_pkg::ONE16; // R02
        end
      end else begin
        if (at_bottom) begin
          down_next = 1'b0;
          cnt_next  = cnt_reg + pfc_pkg::ONE16; // R02
        end else begin
          cnt_next = cnt_reg - pfc_pkg::ONE16; // R02
        end
      end
    end
    if (wr_cyc && avs_address == pfc_pkg::OFF_COUNT) begin
      cnt_next = merge16(cnt_reg, avs_writedata, avs_byteenable);
    end
  end

  // waveform outputs
  always_comb begin
    oca_next = oca_reg;
    ocb_next = ocb_reg;
    if (tick && pfc_mode) begin
      oca_next = wave_next(oca_reg, coma, match_a, slope_down, wgm[3]);
      ocb_next = wave_next(ocb_reg, comb, match_b, slope_down, 1'b0); // R18
    end
  end

  // flags, control and bus registers
  always_comb begin
    flag_set = '0;
    flag_set[pfc_pkg::FLG_OVF]  = reload; // R08
    flag_set[pfc_pkg::FLG_CMPA] = match_a
        || (tick && at_top && !down_reg && wgm == pfc_pkg::WGM_PFC_CMPA); // R09 R10
    flag_set[pfc_pkg::FLG_CMPB] = match_b; // R10
    flag_set[pfc_pkg::FLG_CAPT] = tick && at_top && !down_reg
                                  && wgm == pfc_pkg::WGM_PFC_CAPT; // R09
    ctrl_next  = ctrl_reg;
    bufa_next  = bufa_reg;
    bufb_next  = bufb_reg;
    capt_next  = capt_reg;
    ien_next   = ien_reg;
    pin_next   = pin_reg;
    flag_next  = flag_reg;
    rdata_next = rdata_reg;
    ack_next   = req_new;
    if (wr_cyc) begin
      unique case (avs_address)
        pfc_pkg::OFF_CTRL: ctrl_next = {avs_byteenable[1] ? avs_writedata[10:8] : ctrl_reg[10:8],
                                        avs_byteenable[0] ? avs_writedata[7:0] : ctrl_reg[7:0]};
        pfc_pkg::OFF_CMPA: bufa_next = merge16(bufa_reg, avs_writedata, avs_byteenable);
        pfc_pkg::OFF_CMPB: bufb_next = merge16(bufb_reg, avs_writedata, avs_byteenable);
        pfc_pkg::OFF_CAPT: capt_next = merge16(capt_reg, avs_writedata, avs_byteenable);
        pfc_pkg::OFF_FLAGS: if (avs_byteenable[0]) flag_next = flag_reg & ~avs_writedata[3:0];
        pfc_pkg::OFF_IEN:  if (avs_byteenable[0]) ien_next = avs_writedata[3:0];
        pfc_pkg::OFF_PIN:  if (avs_byteenable[0]) pin_next = avs_writedata[3:0];
        default: ;
      endcase
    end
    flag_next = flag_next | flag_set; // R20: set wins over clear
    if (rd_cyc) begin
      unique case (avs_address)
        pfc_pkg::OFF_CTRL:  rdata_next = {21'h000000, ctrl_reg};
        pfc_pkg::OFF_CMPA:  rdata_next = {16'h0000, bufa_reg};
        pfc_pkg::OFF_CMPB:  rdata_next = {16'h0000, bufb_reg};
        pfc_pkg::OFF_CAPT:  rdata_next = {16'h0000, capt_reg};
        pfc_pkg::OFF_COUNT: rdata_next = {15'h0000, down_reg, cnt_reg};
        pfc_pkg::OFF_FLAGS: rdata_next = {28'h0000000, flag_reg};
        pfc_pkg::OFF_IEN:   rdata_next = {28'h0000000, ien_reg};
        pfc_pkg::OFF_PIN:   rdata_next = {28'h0000000, pin_reg};
        default:            rdata_next = '0;
      endcase
    end
  end

  // pin muxing: waveform only when mode is connected and enabled; output enable from direction
  logic conn_a;
  logic conn_b;
  always_comb begin
    conn_a = pin_reg[pfc_pkg::PIN_ENA] && pfc_mode && (coma[1] || (coma == pfc_pkg::COM_TOGGLE
             && wgm[3])); // R18 R19
    conn_b = pin_reg[pfc_pkg::PIN_ENB] && pfc_mode && comb[1]; // R19
    pin_a_o  = conn_a ? oca_reg : port_a_out; // R13 R19
    pin_b_o  = conn_b ? ocb_reg : port_b_out; // R13 R19
    pin_a_oe = pin_reg[pfc_pkg::PIN_DIRA]; // R13
    pin_b_oe = pin_reg[pfc_pkg::PIN_DIRB]; // R13
  end

  assign irq = |(flag_reg & ien_reg); // R20

  // counter and active compare values
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_reg   <= '0;
      down_reg  <= 1'b0;
      cmpa_reg  <= '0;
      cmpb_reg  <= '0;
    end else begin
      cnt_reg   <= cnt_next;
      down_reg  <= down_next;
      cmpa_reg  <= cmpa_next;
      cmpb_reg  <= cmpb_next;
    end
  end

  // waveform levels
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      oca_reg   <= 1'b0;
      ocb_reg   <= 1'b0;
    end else begin
      oca_reg   <= oca_next;
      ocb_reg   <= ocb_next;
    end
  end

  // software registers, flags and bus answer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bufa_reg  <= '0;
      bufb_reg  <= '0;
      capt_reg  <= '0;
      ctrl_reg  <= '0;
      flag_reg  <= '0;
      ien_reg   <= '0;
      pin_reg   <= '0;
      rdata_reg <= '0;
      ack_reg   <= 1'b0;
    end else begin
      bufa_reg  <= bufa_next;
      bufb_reg  <= bufb_next;
      capt_reg  <= capt_next;
      ctrl_reg  <= ctrl_next;
      flag_reg  <= flag_next;
      ien_reg   <= ien_next;
      pin_reg   <= pin_next;
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
    end
  end
endmodule : pfc_timer

/* File: testbench/pfc_load.sv */
// pfc_load: external load on one pwm pin, pulled down when not driven
// assumes pin level and enable of the timer on the same clock
module pfc_load (
  input  wire logic   clock,
  input  wire logic   pin_o,
  input  wire logic   pin_oe,
  output logic        level,
  output int unsigned highs
);
  timeunit 1ns;
  timeprecision 1ps;
  assign level = pin_oe ? pin_o : 1'h0;
  initial highs = 0;
  always @(posedge clock) if (level) highs <= highs + 1;
endmodule : pfc_load

/* File: testbench/pfc_timer_bench.sv */
// pfc_timer_bench: random dual-slope setups checked by duty, flags and irq
// assumes pfc_timer with pfc_pkg; one pfc_load on each pin
module pfc_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst_n, avs_read, avs_write, port_a_out, port_b_out;
  logic        avs_waitrequest, pin_a_o, pin_a_oe, pin_b_o, pin_b_oe, irq, lvl_a, lvl_b;
  logic [5:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, seed, q;
  int unsigned hi_a, hi_b;
  int          errors, n_compared;

  pfc_timer pfc_timer_i (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .port_a_out(port_a_out), .port_b_out(port_b_out),
    .pin_a_o(pin_a_o), .pin_a_oe(pin_a_oe), .pin_b_o(pin_b_o), .pin_b_oe(pin_b_oe), .irq(irq));
  pfc_load pfc_load_a_i (.clock(clock), .pin_o(pin_a_o), .pin_oe(pin_a_oe), .level(lvl_a),
    .highs(hi_a));
  pfc_load pfc_load_b_i (.clock(clock), .pin_o(pin_b_o), .pin_oe(pin_b_oe), .level(lvl_b),
    .highs(hi_b));

  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // high cycles over four periods: 2*cmp ticks a period, or the rest when inverted
  function automatic int unsigned exp_hi(input logic [1:0] com, input int unsigned c,
                                         input int unsigned t, input int unsigned n);
    return (com == pfc_pkg::COM_INV) ? 8 * n * (t - c) : 8 * n * c;
  endfunction : exp_hi

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    @(posedge clock);
    while (avs_waitrequest !== 1'h0 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (n == 50) begin
      errors++;
      $display("mismatch at %0t: bus request not answered", $time);
      end_of_test();
    end else begin
      q = avs_readdata;
      avs_write <= 1'h0;
      avs_read  <= 1'h0;
    end
  endtask : bus

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(q, e);
  endtask : rd

  initial begin
    repeat (40000) @(posedge clock);
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    int unsigned t, ca, cb, n, h_a, h_b;
    logic [1:0]  coma;
    logic [3:0]  mode;
    logic [2:0]  cs;
    logic [31:0] r;
    seed = 32'h26;
    {rst_n, avs_read, avs_write, port_a_out, port_b_out} = 5'h0;
    avs_address = 6'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h3;
    errors = 0;
    n_compared = 0;
    repeat (10) @(posedge clock);
    rst_n <= 1'h1;
    rd(pfc_pkg::OFF_CTRL, 32'h0);
    rd(6'h20, 32'h0);
    bus(1'h1, pfc_pkg::OFF_PIN, 32'hF);
    bus(1'h1, pfc_pkg::OFF_IEN, 32'h1);
    for (int i = 0; i < 6; i++) begin
      r = xs();
      n = (i < 4) ? 1 : 8;
      cs = (i < 4) ? pfc_pkg::CS_1 : pfc_pkg::CS_8;
      mode = i[0] ? pfc_pkg::WGM_PFC_CMPA : pfc_pkg::WGM_PFC_CAPT;
      coma = r[0] ? pfc_pkg::COM_NONINV : pfc_pkg::COM_INV;
      t = 3 + xs() % 18;
      ca = (mode == pfc_pkg::WGM_PFC_CMPA) ? t : xs() % (t + 1);
      cb = xs() % (t + 1);
      bus(1'h1, pfc_pkg::OFF_CTRL, 32'h0);
      bus(1'h1, pfc_pkg::OFF_COUNT, 32'h0);
      bus(1'h1, pfc_pkg::OFF_FLAGS, 32'hF);
      bus(1'h1, pfc_pkg::OFF_CMPA, ca);
      bus(1'h1, pfc_pkg::OFF_CMPB, cb);
      bus(1'h1, pfc_pkg::OFF_CAPT, t);
      port_a_out <= r[1];
      port_b_out <= r[2];
      bus(1'h1, pfc_pkg::OFF_CTRL, {21'h0, cs, pfc_pkg::COM_INV, coma, mode});
      repeat (48 * n + 8) @(posedge clock);
      @(negedge clock);
      h_a = hi_a;
      h_b = hi_b;
      repeat (8 * t * n) @(negedge clock);
      chk(hi_a - h_a, exp_hi(coma, ca, t, n));
      chk(hi_b - h_b, exp_hi(pfc_pkg::COM_INV, cb, t, n));
      bus(1'h0, pfc_pkg::OFF_COUNT, 32'h0);
      chk({31'h0, q[15:0] <= t[15:0]}, 32'h1);
      rd(pfc_pkg::OFF_FLAGS, (mode == pfc_pkg::WGM_PFC_CAPT) ? 32'hF : 32'h7);
      chk({31'h0, irq}, 32'h1);
    end
    bus(1'h1, pfc_pkg::OFF_CTRL, 32'h0);
    bus(1'h1, pfc_pkg::OFF_COUNT, 32'hFFFF);
    bus(1'h1, pfc_pkg::OFF_FLAGS, 32'hF);
    rd(pfc_pkg::OFF_FLAGS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    end_of_test();
  end
endmodule : pfc_timer_bench

/* File: testbench/pfc_timer_checker.sv */
// pfc_timer_checker: port-level assertions for the dual-slope pwm timer
// assumes binding onto pfc_timer; shadows pin and ctrl writes seen on the bus
module pfc_timer_checker (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        port_a_out,
  input wire logic        port_b_out,
  input wire logic        pin_a_o,
  input wire logic        pin_a_oe,
  input wire logic        pin_b_o,
  input wire logic        pin_b_oe,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       en_a_reg;
  logic [1:0] com_a_reg;
  logic       take_w;
  assign take_w = avs_write && !avs_waitrequest && avs_byteenable[0];
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      en_a_reg  <= 1'h0;
      com_a_reg <= 2'h0;
    end else begin
      if (take_w && avs_address == pfc_pkg::OFF_PIN) en_a_reg <= avs_writedata[pfc_pkg::PIN_ENA];
      if (take_w && avs_address == pfc_pkg::OFF_CTRL) begin
        com_a_reg <= avs_writedata[pfc_pkg::CTRL_COMA_LSB +: 2];
      end
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_pin_wr; take_w && avs_address == pfc_pkg::OFF_PIN; endsequence
  property p_ack; s_req |=> !avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("request not answered after one cycle");
  property p_idle; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("waitrequest high while idle");
  property p_rdata; !(avs_read && avs_waitrequest) |=> $stable(avs_readdata); endproperty
  a_rdata: assert property (p_rdata) else $error("readdata changed without a read");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address > pfc_pkg::OFF_PIN |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_oe_a; s_pin_wr |=> pin_a_oe == $past(avs_writedata[pfc_pkg::PIN_DIRA]); endproperty
  a_oe_a: assert property (p_oe_a) else $error("pin a enable not from direction");
  property p_oe_b; s_pin_wr |=> pin_b_oe == $past(avs_writedata[pfc_pkg::PIN_DIRB]); endproperty
  a_oe_b: assert property (p_oe_b) else $error("pin b enable not from direction");
  property p_port_a;
    (!en_a_reg || com_a_reg == pfc_pkg::COM_OFF) |-> pin_a_o == port_a_out;
  endproperty
  a_port_a: assert property (p_port_a) else $error("pin a not on port data");
  property p_rst; $rose(rst_n) |-> !irq && !pin_a_oe && !pin_b_oe; endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule : pfc_timer_checker

bind pfc_timer pfc_timer_checker pfc_timer_checker_i (.clock(clock), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .port_a_out(port_a_out), .port_b_out(port_b_out), .pin_a_o(pin_a_o),
  .pin_a_oe(pin_a_oe), .pin_b_o(pin_b_o), .pin_b_oe(pin_b_oe), .irq(irq));
